// ===== lbr_core.sv
/*
 * lbr_core: branch and zero-overhead loop resolution, loop attribute cache,
 * context-restore forwarding guard and data debug events.
 * assumes fetch/decode/execute stage signals synchronous to clk_sys, one-cycle strobes.
 */
// Local design decisions: the Avalon-MM interface to the registers and the address map.
// Function
// RULE_01 - predict conditional jumps taken, except 32-bit forward jumps predicted not taken
// RULE_02 - jump in execute beats loop in decode resolving same cycle
// RULE_03 - mispredicted conditional loop cancels target unconditional loop, resumes after it
// RULE_04 - loop prediction uses counter value written by directly preceding instruction
// RULE_05 - two loop cache buffers hold attributes of two distinct loops
// RULE_06 - each entry records global register write; only conditional loops use it
// RULE_07 - write-protect trap only for global counter and permit bit zero
// RULE_08 - global write flag stored per entry, unaffected by other entries
// RULE_09 - unconditional loop opcode bits 15:12 never decoded as a register
// RULE_10 - context restore loads context pointer from stored context, never return address
// RULE_11 - A0/A1 readers after context restore get register contents, not forwarded data
// RULE_12 - segments 0xe and 0xf bypass range memory protection
// RULE_13 - comparators raise data debug events in every segment, peripherals included
`timescale 1ns/1ps
module lbr_core (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // execute stage conditional jump
  input  wire logic        ex_jump_valid,
  input  wire logic        ex_jump_taken,
  input  wire logic        ex_jump_pred,
  input  wire logic [31:0] ex_jump_target,
  input  wire logic [31:0] ex_jump_fallthru,
  // decode stage jump for prediction
  input  wire logic        dec_jump_valid,
  input  wire logic        dec_jump_wide,
  input  wire logic        dec_jump_forward,
  // decode stage loop
  input  wire logic        dec_loop_valid,
  input  wire logic        dec_loop_cond,
  input  wire logic [31:0] dec_loop_pc,
  input  wire logic [31:0] dec_loop_target,
  input  wire logic [31:0] dec_loop_fallthru,
  input  wire logic [15:0] dec_loop_opcode,
  input  wire logic [31:0] dec_loop_count,
  input  wire logic        dec_loop_target_uncond,
  // preceding instruction writeback of address register
  input  wire logic        prev_awr_valid,
  input  wire logic [3:0]  prev_awr_idx,
  input  wire logic [31:0] prev_awr_data,
  // context restore and next load-store/loop reader
  input  wire logic        ctx_restore_valid,
  input  wire logic [31:0] ctx_stored_pcx,
  input  wire logic [31:0] ctx_return_addr,
  input  wire logic        ls_valid,
  input  wire logic [3:0]  ls_src1_idx,
  input  wire logic [3:0]  ls_src2_idx,
  input  wire logic [31:0] ls_src1_reg,
  input  wire logic [31:0] ls_src2_reg,
  // data access for protection and debug
  input  wire logic        dacc_valid,
  input  wire logic [31:0] dacc_addr,
  input  wire logic        dacc_range_ok,
  input  wire logic        dacc_cmp_hit,
  // outputs
  output logic             dec_jump_predict_taken,
  output logic             redirect_valid,
  output logic      [31:0] redirect_pc,
  output logic             cancel_decode_loop,
  output logic             global_write_protect_trap,
  output logic      [31:0] previous_context_pointer,
  output logic      [31:0] ls_src1_value,
  output logic      [31:0] ls_src2_value,
  output logic             range_prot_fault,
  output logic             dbg_data_event
);
  import lbr_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_global_areg(input logic [3:0] idx);
    is_global_areg = (idx == AREG_A0) || (idx == AREG_A1) ||
                     (idx == AREG_A8) || (idx == AREG_A9);
  endfunction : is_global_areg

  function automatic logic is_periph_seg(input logic [31:0] addr);
    is_periph_seg = (addr[31:28] == SEG_PERIPH_E) || (addr[31:28] == SEG_PERIPH_F);
  endfunction : is_periph_seg

  // ****************************************
  // registers
  // ****************************************
  logic [1:0]  ctrl;
  logic [31:0] evcnt;
  logic        trap_sticky;
  logic [31:0] lc_pc     [LOOP_ENTRIES];
  logic        lc_valid  [LOOP_ENTRIES];
  logic        lc_cond   [LOOP_ENTRIES];
  logic        lc_gwr    [LOOP_ENTRIES];
  logic        lc_victim;

  wire global_write_permit_bit = ctrl[CTRL_GW_BIT];
  wire dbg_enable              = ctrl[CTRL_DBG_BIT];

  // ****************************************
  // jump prediction
  // ****************************************
  // RULE_01 wide forward not taken
  wire next_predict = dec_jump_valid & ~(dec_jump_wide & dec_jump_forward);

  // ****************************************
  // loop resolution
  // ****************************************
  // RULE_04 forward fresh counter
  wire        cnt_fwd   = prev_awr_valid && (prev_awr_idx == dec_loop_opcode[11:8]);
  wire [31:0] loop_cnt  = cnt_fwd ? prev_awr_data : dec_loop_count;
  // RULE_09 uncond ignores 15:12
  wire [3:0]  cnt_idx   = dec_loop_opcode[11:8];
  wire        loop_gwr  = dec_loop_cond & is_global_areg(cnt_idx);
  wire        loop_exit = dec_loop_cond && (loop_cnt == WORD_ZERO);
  wire        jump_mis  = ex_jump_valid && (ex_jump_taken != ex_jump_pred);

  // RULE_05 two-entry lookup
  wire        hit0 = lc_valid[0] && (lc_pc[0] == dec_loop_pc);
  wire        hit1 = lc_valid[1] && (lc_pc[1] == dec_loop_pc);
  wire        hit_any = hit0 | hit1;
  wire        hit_idx = hit1;
  wire        fill_idx = hit_any ? hit_idx : lc_victim;
  // RULE_06 cond loops consult own flag
  wire        cached_gwr = hit_any && lc_cond[hit_idx] && lc_gwr[hit_idx];
  wire        uses_gwr   = dec_loop_cond & (cached_gwr | loop_gwr);
  // RULE_07 trap condition
  wire        next_trap  = dec_loop_valid & ~jump_mis & uses_gwr & ~global_write_permit_bit;

  lbr_npc_t   npc_sel;
  // RULE_02 jump wins over loop
  // RULE_03 exit resumes after cond loop
  assign npc_sel = jump_mis                   ? LBR_NPC_JUMP :
                   (dec_loop_valid & loop_exit) ? LBR_NPC_EXIT :
                   dec_loop_valid             ? LBR_NPC_LOOP : LBR_NPC_SEQ;

  wire [31:0] jump_pc = ex_jump_taken ? ex_jump_target : ex_jump_fallthru;
  wire [31:0] next_pc = (npc_sel == LBR_NPC_JUMP) ? jump_pc :
                        (npc_sel == LBR_NPC_EXIT) ? dec_loop_fallthru :
                        dec_loop_target;
  wire next_redirect = (npc_sel != LBR_NPC_SEQ) & ~next_trap;
  // RULE_03 cancel targeted uncond loop
  wire next_cancel = jump_mis | ((npc_sel == LBR_NPC_EXIT) & dec_loop_target_uncond);

  // ****************************************
  // context restore forwarding guard
  // ****************************************
  // RULE_10 pointer from stored context
  wire [31:0] next_pcx = ctx_restore_valid ? ctx_stored_pcx : previous_context_pointer;
  // RULE_11 no forwarding from restore
  wire [31:0] next_src1 = ls_valid ? ls_src1_reg : ls_src1_value;
  wire [31:0] next_src2 = ls_valid ? ls_src2_reg : ls_src2_value;

  // ****************************************
  // protection and debug
  // ****************************************
  // RULE_12 peripheral segments bypass
  wire next_fault = dacc_valid & ~is_periph_seg(dacc_addr) & ~dacc_range_ok;
  // RULE_13 events in all segments
  wire next_dbg   = dacc_valid & dacc_cmp_hit & dbg_enable;

  // ****************************************
  // avalon slave decode
  // ****************************************
  wire sel_ctrl   = avs_address == REG_CTRL;
  wire sel_status = avs_address == REG_STATUS;
  wire sel_loop0  = avs_address == REG_LOOP0;
  wire sel_loop1  = avs_address == REG_LOOP1;
  wire sel_evcnt  = avs_address == REG_EVCNT;
  wire acc        = (avs_read | avs_write) & avs_waitrequest;
  wire [31:0] rd_mux =
    sel_ctrl   ? {30'h0, ctrl} :
    sel_status ? {28'h0, lc_gwr[1], lc_gwr[0], lc_victim, trap_sticky} :
    sel_loop0  ? lc_pc[0] :
    sel_loop1  ? lc_pc[1] :
    sel_evcnt  ? evcnt : WORD_ZERO;
  wire wr_ctrl    = acc & avs_write & sel_ctrl & avs_byteenable[0];
  wire clr_status = acc & avs_write & sel_status & avs_byteenable[0] & avs_writedata[0];

  // ****************************************
  // sequential logic
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= WORD_ZERO;
    end else begin
      avs_waitrequest <= ~acc;
      avs_readdata    <= (acc & avs_read) ? rd_mux : avs_readdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl        <= CTRL_RESET;
      trap_sticky <= 1'b0;
      evcnt       <= WORD_ZERO;
    end else begin
      if (wr_ctrl) ctrl <= avs_writedata[1:0];
      trap_sticky <= next_trap | (trap_sticky & ~clr_status);
      if (next_dbg) evcnt <= evcnt + 32'h1;
    end
  end

  // RULE_08 per-entry flag update
  genvar gi;
  generate
    for (gi = 0; gi < LOOP_ENTRIES; gi++) begin : g_lc
      wire fill = dec_loop_valid & ~jump_mis & (fill_idx == 1'(gi));
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          lc_valid[gi] <= 1'b0;
          lc_pc[gi]    <= WORD_ZERO;
          lc_cond[gi]  <= 1'b0;
          lc_gwr[gi]   <= 1'b0;
        end else if (fill) begin
          lc_valid[gi] <= 1'b1;
          lc_pc[gi]    <= dec_loop_pc;
          lc_cond[gi]  <= dec_loop_cond;
          lc_gwr[gi]   <= loop_gwr;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lc_victim <= 1'b0;
    end else if (dec_loop_valid & ~jump_mis & ~hit_any) begin
      lc_victim <= ~lc_victim;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // RULE_01 prediction output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_jump_predict_taken <= 1'b0;
    end else begin
      dec_jump_predict_taken <= next_predict;
    end
  end

  // RULE_02 redirect and cancel
  // RULE_03 exit redirect outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      redirect_valid     <= 1'b0;
      redirect_pc        <= WORD_ZERO;
      cancel_decode_loop <= 1'b0;
    end else begin
      redirect_valid     <= next_redirect;
      redirect_pc        <= next_pc;
      cancel_decode_loop <= next_cancel;
    end
  end

  // RULE_07 trap pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      global_write_protect_trap <= 1'b0;
    end else begin
      global_write_protect_trap <= next_trap;
    end
  end

  // RULE_10 context pointer output
  // RULE_11 operand outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      previous_context_pointer <= WORD_ZERO;
      ls_src1_value            <= WORD_ZERO;
      ls_src2_value            <= WORD_ZERO;
    end else begin
      previous_context_pointer <= next_pcx;
      ls_src1_value            <= next_src1;
      ls_src2_value            <= next_src2;
    end
  end

  // RULE_12 fault output
  // RULE_13 debug event output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      range_prot_fault <= 1'b0;
      dbg_data_event   <= 1'b0;
    end else begin
      range_prot_fault <= next_fault;
      dbg_data_event   <= next_dbg;
    end
  end
endmodule : lbr_core

// ===== lbr_pkg.sv
/*
 * lbr_pkg: constants shared by the loop and branch resolution block.
 * assumes a single core clock domain and a software register map over Avalon-MM.
 */
package lbr_pkg;
  // ****************************************
  // register map (word offsets in bytes)
  // ****************************************
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_LOOP0    = 8'h08;
  localparam logic [7:0]  REG_LOOP1    = 8'h0c;
  localparam logic [7:0]  REG_EVCNT    = 8'h10;
  // ctrl fields
  localparam int          CTRL_GW_BIT  = 0;
  localparam int          CTRL_DBG_BIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h2;
  // segment codes of the peripheral space
  localparam logic [3:0]  SEG_PERIPH_E = 4'he;
  localparam logic [3:0]  SEG_PERIPH_F = 4'hf;
  // address register indices
  localparam logic [3:0]  AREG_A0      = 4'h0;
  localparam logic [3:0]  AREG_A1      = 4'h1;
  localparam logic [3:0]  AREG_A8      = 4'h8;
  localparam logic [3:0]  AREG_A9      = 4'h9;
  // loop cache
  localparam int          LOOP_ENTRIES = 2;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  // next-pc source select
  typedef enum logic [1:0] {
    LBR_NPC_SEQ  = 2'b00,
    LBR_NPC_JUMP = 2'b01,
    LBR_NPC_LOOP = 2'b10,
    LBR_NPC_EXIT = 2'b11
  } lbr_npc_t;
endpackage : lbr_pkg

// ===== lbr_core_props_props.sv
/* lbr_core_props: port checker for lbr_core.
   assumes a bind onto lbr_core, one clock clk_sys. */
`timescale 1ns/1ps
module lbr_core_props (
  input wire logic        clk_sys, rst_n, dec_jump_valid, dec_jump_wide, dec_jump_forward,
  input wire logic        ex_jump_valid, ex_jump_taken, ex_jump_pred, dec_loop_valid,
  input wire logic        dec_loop_cond, ctx_restore_valid, ls_valid, dacc_valid, dacc_cmp_hit,
  input wire logic [31:0] ex_jump_target, ex_jump_fallthru, dec_loop_fallthru, ctx_stored_pcx,
  input wire logic [31:0] ls_src1_reg, ls_src2_reg, dacc_addr, redirect_pc,
  input wire logic [31:0] previous_context_pointer, ls_src1_value, ls_src2_value,
  input wire logic        dec_jump_predict_taken, redirect_valid, cancel_decode_loop,
  input wire logic        global_write_protect_trap, range_prot_fault, dbg_data_event
);
  // ****************
  // defaults, helpers
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic        mis    = ex_jump_valid && (ex_jump_taken != ex_jump_pred);
  wire logic [31:0] jmp_pc = ex_jump_taken ? ex_jump_target : ex_jump_fallthru;
  // ****************
  // assertions
  // ****************
  a_fwd_not_taken: assert property (dec_jump_valid && dec_jump_wide && dec_jump_forward
    |=> !dec_jump_predict_taken) else $error("wide forward jump predicted taken");
  a_others_taken: assert property (dec_jump_valid && !(dec_jump_wide && dec_jump_forward)
    |=> dec_jump_predict_taken) else $error("jump predicted not taken");
  a_jump_first: assert property (mis |=> redirect_valid && redirect_pc == $past(jmp_pc))
    else $error("jump redirect wrong");
  a_jump_cancel: assert property (mis && dec_loop_valid |=> cancel_decode_loop)
    else $error("loop not cancelled by jump");
  a_uncond_exit: assert property (cancel_decode_loop && redirect_valid && !$past(mis)
    |-> redirect_pc == $past(dec_loop_fallthru)) else $error("exit pc wrong");
  a_ctx_pointer: assert property (ctx_restore_valid
    |=> previous_context_pointer == $past(ctx_stored_pcx)) else $error("context pointer wrong");
  a_ls_no_fwd: assert property (ls_valid |=> ls_src1_value == $past(ls_src1_reg)
    && ls_src2_value == $past(ls_src2_reg)) else $error("operand forwarded");
  a_periph_no_fault: assert property (dacc_valid && dacc_addr[31:29] == 3'h7
    |=> !range_prot_fault) else $error("fault in peripheral segment");
  a_trap_cause: assert property (global_write_protect_trap
    |-> $past(dec_loop_valid) && $past(dec_loop_cond)) else $error("trap without loop");
  a_dbg_cause: assert property (dbg_data_event
    |-> $past(dacc_valid) && $past(dacc_cmp_hit)) else $error("event without hit");
  c_cancel: cover property (redirect_valid && cancel_decode_loop);
  c_trap: cover property (global_write_protect_trap);
  c_dbg: cover property (dbg_data_event);
endmodule : lbr_core_props
bind lbr_core lbr_core_props u_props (.*);

// ===== lbr_dec_model.sv
/* lbr_dec_model: decode-stage loop instruction source.
   assumes the bench picks a slot and holds go one cycle. */
`timescale 1ns/1ps
module lbr_dec_model (
  // bench control
  input  wire logic        go, cond,
  input  wire logic [1:0]  slot,
  input  wire logic [3:0]  cnt_idx,
  // decode loop fields
  output logic             dec_loop_valid, dec_loop_cond,
  output logic      [31:0] dec_loop_pc, dec_loop_target, dec_loop_fallthru,
  output logic      [15:0] dec_loop_opcode
);
  assign dec_loop_valid    = go;
  assign dec_loop_cond     = cond;
  assign dec_loop_pc       = 32'h0000_0100 + {24'h0, slot, 6'h00};
  assign dec_loop_target   = dec_loop_pc - 32'h0000_0020;
  assign dec_loop_fallthru = dec_loop_pc + 32'h0000_0004;
  assign dec_loop_opcode   = cond ? {4'h0, cnt_idx, 8'h00} : 16'h0f00;
endmodule : lbr_dec_model

// ===== loop_branch_resolution_tb.sv
/* loop_branch_resolution_tb: directed bench for lbr_core.
   assumes lbr_dec_model as decode source and the checker bound. */
`timescale 1ns/1ps
module loop_branch_resolution_tb;
  import lbr_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0, cond = 1'b0;
  logic ex_jump_valid = 1'b0, ex_jump_taken = 1'b0, ex_jump_pred = 1'b0, dec_jump_valid = 1'b0;
  logic dec_jump_wide = 1'b0, dec_jump_forward = 1'b0, dec_loop_target_uncond = 1'b0;
  logic prev_awr_valid = 1'b0, ctx_restore_valid = 1'b0, ls_valid = 1'b0, dacc_valid = 1'b0;
  logic dacc_range_ok = 1'b0, dacc_cmp_hit = 1'b0;
  logic [1:0] slot = 2'h0;
  logic [3:0] avs_byteenable = 4'hf, cnt_idx = 4'h0, prev_awr_idx = 4'h0;
  logic [3:0] ls_src1_idx = 4'h1, ls_src2_idx = 4'h0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, ex_jump_target = 32'h0, ex_jump_fallthru = 32'h0;
  logic [31:0] dec_loop_count = 32'h0, prev_awr_data = 32'h0, ctx_stored_pcx = 32'h0;
  logic [31:0] ctx_return_addr = 32'h0, ls_src1_reg = 32'h0, ls_src2_reg = 32'h0;
  logic [31:0] dacc_addr = 32'h0, q0, q1;
  wire logic [31:0] avs_readdata, redirect_pc, previous_context_pointer, ls_src1_value;
  wire logic [31:0] ls_src2_value, dec_loop_pc, dec_loop_target, dec_loop_fallthru;
  wire logic [15:0] dec_loop_opcode;
  wire logic avs_waitrequest, dec_jump_predict_taken, redirect_valid, cancel_decode_loop;
  wire logic global_write_protect_trap, range_prot_fault, dbg_data_event;
  wire logic dec_loop_valid, dec_loop_cond;
  int err_count = 0, checks_done = 0, cyc = 0;
  lbr_core dut (.*);
  lbr_dec_model u_dec (.*);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    checks_done++;
    if (act !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : chk
  // ****************
  // avalon master and staging
  // ****************
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a; avs_write <= wr; avs_read <= !wr; avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0);
    chk(n, 32'h2);
    q = avs_readdata;
    avs_read <= 1'b0; avs_write <= 1'b0;
  endtask : bus
  task automatic stage_loop(input logic c, input logic [1:0] s, input logic [3:0] ix,
                            input logic [31:0] n, input logic u);
    go <= 1'b1; cond <= c; slot <= s; cnt_idx <= ix; dec_loop_count <= n;
    dec_loop_target_uncond <= u;
  endtask : stage_loop
  task automatic issue();
    @(posedge clk_sys);
    go <= 1'b0; ex_jump_valid <= 1'b0; dec_jump_valid <= 1'b0; prev_awr_valid <= 1'b0;
    ctx_restore_valid <= 1'b0; ls_valid <= 1'b0; dacc_valid <= 1'b0;
    #1;
  endtask : issue
  // ****************
  // scenarios
  // ****************
  task automatic t_pred();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      dec_jump_valid <= 1'b1; dec_jump_wide <= i[0]; dec_jump_forward <= i[1];
      issue();
      chk(dec_jump_predict_taken, {31'h0, i != 3});
    end
    $display("test pred done");
  endtask : t_pred
  task automatic t_flow();
    @(posedge clk_sys);
    ex_jump_valid <= 1'b1; ex_jump_taken <= 1'b1; ex_jump_target <= 32'h0000_0800;
    stage_loop(1'b1, 2'h0, 4'h6, 32'h0, 1'b0);
    issue();
    chk({redirect_valid, cancel_decode_loop, redirect_pc[29:0]}, 32'hc000_0800);
    @(posedge clk_sys);
    stage_loop(1'b1, 2'h1, 4'h6, 32'h0, 1'b1);
    issue();
    chk({redirect_valid, cancel_decode_loop, redirect_pc[29:0]}, 32'hc000_0144);
    @(posedge clk_sys);
    prev_awr_valid <= 1'b1; prev_awr_idx <= 4'h6; prev_awr_data <= 32'h5;
    stage_loop(1'b1, 2'h1, 4'h6, 32'h0, 1'b0);
    issue();
    chk({redirect_valid, cancel_decode_loop, redirect_pc[29:0]}, 32'h8000_0120);
    $display("test flow done");
  endtask : t_flow
  task automatic t_cache();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      stage_loop(i != 1, {1'b1, i[0]}, 4'h5, 32'h3, 1'b0);
      issue();
      chk(global_write_protect_trap, 32'h0);
    end
    bus(1'b0, REG_LOOP0, 32'h0, q0);
    bus(1'b0, REG_LOOP1, 32'h0, q1);
    chk({31'h0, (q0 ^ q1) == 32'h40 && (q0 | q1) == 32'h1c0}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, REG_CTRL, {30'h0, CTRL_RESET[1], p[0]}, q0);
      @(posedge clk_sys);
      stage_loop(1'b1, 2'h0, AREG_A8, 32'h3, 1'b0);
      issue();
      chk(global_write_protect_trap, {31'h0, p == 0});
    end
    bus(1'b0, REG_STATUS, 32'h0, q0);
    chk(q0[0], 32'h1);
    $display("test cache done");
  endtask : t_cache
  task automatic t_ctx_seg();
    @(posedge clk_sys);
    ctx_restore_valid <= 1'b1; ctx_stored_pcx <= 32'h0003_0040;
    ctx_return_addr <= 32'h8000_1234; ls_src1_reg <= 32'h1111_0000; ls_src2_reg <= 32'h2222_0000;
    @(posedge clk_sys);
    ctx_restore_valid <= 1'b0; ls_valid <= 1'b1;
    issue();
    chk(previous_context_pointer, 32'h0003_0040);
    chk(ls_src1_value, 32'h1111_0000);
    chk(ls_src2_value, 32'h2222_0000);
    for (int s = 12; s < 16; s++) begin
      @(posedge clk_sys);
      dacc_valid <= 1'b1; dacc_addr <= {s[3:0], 28'h000_0100}; dacc_cmp_hit <= 1'b1;
      issue();
      chk({range_prot_fault, dbg_data_event}, {30'h0, s < 14, 1'b1});
    end
    bus(1'b0, 8'h1c, 32'h0, q0);
    chk(q0, 32'h0);
    $display("test ctx and segments done");
  endtask : t_ctx_seg
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0, q0);
    chk(q0, {30'h0, CTRL_RESET});
    t_pred();
    t_flow();
    t_cache();
    t_ctx_seg();
    print_verdict();
  end
endmodule : loop_branch_resolution_tb
